// *** trigger_pulse_powerfail_ctrl.sv ***
`timescale 1ns/100ps
`include "trigger_pulse_powerfail_regs.svh"

module trigger_pulse_powerfail_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command side
    input wire trigger_pulse_powerfail_pkg::trg_cmd_t trg_cmd,
    input wire trigger_pulse_powerfail_pkg::pf_cmd_t pf_cmd,
    input wire logic [2:0] query_line,
    output logic query_enabled,
    output logic [`TRG_LINES-1:0] trg_enable,
    output logic powerfail_action_value,
    // Scan sequencer
    input wire logic close_dwell_done,
    output logic pulse_busy,
    // Backplane trigger lines, open drain
    input wire logic [`TRG_LINES-1:0] ttl_trg_in,
    output logic [`TRG_LINES-1:0] ttl_trg_out,
    output logic [`TRG_LINES-1:0] ttl_trg_oe,
    // Power fail and relays
    input wire logic acfail_n,
    output logic open_all_relays
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic arg_enables(input logic [1:0] kind, input logic [7:0] number);
        arg_enables = (kind == `ARG_ON) || ((kind == `ARG_NUM) && (number == 8'h01));
    endfunction

    // One command touches one line; every other line keeps its enable
    function automatic logic [`TRG_LINES-1:0] enables_after(
        input logic [`TRG_LINES-1:0] en,
        input trigger_pulse_powerfail_pkg::trg_cmd_t cmd
    );
        enables_after = en;
        if (cmd.valid) begin
            enables_after[cmd.line] = arg_enables(cmd.kind, cmd.number);
        end
    endfunction

    function automatic logic pulse_may_start(input logic done, input logic [`TRG_LINES-1:0] en);
        pulse_may_start = done && (en != '0);
    endfunction

    // Rounded up, so a pulse is never shorter than asked for
    localparam logic [7:0] PULSE_CYC = 8'(`TRG_PULSE_CYC);

    // ****************************************
    // Enables and action
    // ****************************************
    logic [`TRG_LINES-1:0] en_reg;
    logic [`TRG_LINES-1:0] en_next;
    logic action_reg;
    logic action_next;

    always_comb begin
        en_next = enables_after(en_reg, trg_cmd);
        action_next = action_reg;
        if (pf_cmd.valid) begin
            action_next = pf_cmd.action;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_reg <= `TRG_EN_RESET;
            action_reg <= `PF_ACTION_RESET;
        end else begin
            en_reg <= en_next;
            action_reg <= action_next;
        end
    end

    // ****************************************
    // Trigger pulse
    // ****************************************
    trigger_pulse_powerfail_pkg::trg_state_t st_reg;
    trigger_pulse_powerfail_pkg::trg_state_t st_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    // Lines captured at the start, so later enable changes leave a pulse in flight alone
    logic [`TRG_LINES-1:0] drive_reg;
    logic [`TRG_LINES-1:0] drive_next;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        drive_next = drive_reg;
        case (st_reg)
            trigger_pulse_powerfail_pkg::ST_IDLE: begin
                if (pulse_may_start(close_dwell_done, en_reg)) begin
                    st_next = trigger_pulse_powerfail_pkg::ST_PULSE;
                    cnt_next = PULSE_CYC - 8'h01;
                    drive_next = en_reg;
                end
            end
            trigger_pulse_powerfail_pkg::ST_PULSE: begin
                if (cnt_reg == 8'h00) begin
                    st_next = trigger_pulse_powerfail_pkg::ST_IDLE;
                    drive_next = '0;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: begin
                st_next = trigger_pulse_powerfail_pkg::ST_IDLE;
                drive_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= trigger_pulse_powerfail_pkg::ST_IDLE;
            cnt_reg <= 8'h00;
            drive_reg <= '0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            drive_reg <= drive_next;
        end
    end

    // ****************************************
    // Power fail
    // ****************************************
    // Backplane pin is not on our clock, two flops before any use
    logic acfail_s1_reg;
    logic acfail_s1_next;
    logic acfail_s2_reg;
    logic acfail_s2_next;

    always_comb begin
        acfail_s1_next = acfail_n;
        acfail_s2_next = acfail_s1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acfail_s1_reg <= 1'b1;
            acfail_s2_reg <= 1'b1;
        end else begin
            acfail_s1_reg <= acfail_s1_next;
            acfail_s2_reg <= acfail_s2_next;
        end
    end

    // Sticky until reset, so the relays keep the open order while hold-up power lasts
    logic pf_open_reg;
    logic pf_open_next;

    always_comb begin
        pf_open_next = pf_open_reg;
        if (!acfail_s2_reg) begin
            case (action_reg)
                `PF_ACTION_OPEN: begin
                    pf_open_next = 1'b1;
                end
                `PF_ACTION_SAME: begin
                    pf_open_next = pf_open_reg;
                end
                default: begin
                    pf_open_next = pf_open_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pf_open_reg <= 1'b0;
        end else begin
            pf_open_reg <= pf_open_next;
        end
    end

    // ****************************************
    // Status query
    // ****************************************
    // A flop output, so the answer follows the line select by one cycle
    logic query_reg;
    logic query_next;

    always_comb begin
        query_next = en_next[query_line];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            query_reg <= 1'b0;
        end else begin
            query_reg <= query_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Line read-back unused: line is only driven low, never sensed here
    assign ttl_trg_out = '0;
    assign ttl_trg_oe = drive_reg;
    // Busy is a handshake, so a state decode is enough
    assign pulse_busy = (st_reg == trigger_pulse_powerfail_pkg::ST_PULSE);
    assign query_enabled = query_reg;
    assign trg_enable = en_reg;
    assign powerfail_action_value = action_reg;
    assign open_all_relays = pf_open_reg;

endmodule

// *** trigger_pulse_powerfail_regs.svh ***
`ifndef TRIGGER_PULSE_POWERFAIL_REGS_SVH
`define TRIGGER_PULSE_POWERFAIL_REGS_SVH

// ****************************************
// Sizes, reset values and timing
// ****************************************
`define TRG_LINES 8
`define CLK_PERIOD_NS 20
`define TRG_PULSE_NS 3000
`define TRG_PULSE_CYC ((`TRG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRG_EN_RESET 8'h00
`define PF_ACTION_RESET 1'b0
`define PF_ACTION_OPEN 1'b0
`define PF_ACTION_SAME 1'b1
`define ARG_OFF 2'h0
`define ARG_ON 2'h1
`define ARG_NUM 2'h2

`endif

// *** trigger_pulse_powerfail_pkg.sv ***
package trigger_pulse_powerfail_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PULSE = 2'b01
    } trg_state_t;

    typedef struct packed {
        logic valid;
        logic [2:0] line;
        logic [1:0] kind;
        logic [7:0] number;
    } trg_cmd_t;

    typedef struct packed {
        logic valid;
        logic action;
    } pf_cmd_t;

endpackage

// *** trigger_pulse_powerfail_ctrl_monitor.sv ***
`timescale 1ns/100ps
`include "trigger_pulse_powerfail_regs.svh"
// ****
// Port checks
// ****
module trigger_pulse_powerfail_ctrl_monitor (
    input wire logic clk, rst, close_dwell_done, pulse_busy, query_enabled, acfail_n,
    input wire logic powerfail_action_value, open_all_relays,
    input wire logic [2:0] query_line,
    input wire logic [7:0] trg_enable, ttl_trg_oe,
    input wire trigger_pulse_powerfail_pkg::trg_cmd_t trg_cmd,
    input wire trigger_pulse_powerfail_pkg::pf_cmd_t pf_cmd
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] cnt;
    wire want = trg_cmd.kind == `ARG_ON || trg_cmd.kind == `ARG_NUM && trg_cmd.number == 8'h01;
    // Width counted here, not trusted from the state register
    always_ff @(posedge clk) cnt <= pulse_busy && !rst ? cnt + 8'h01 : 8'h00;
    chk_pulse_start: assert property (close_dwell_done && !pulse_busy && |trg_enable
        |=> ttl_trg_oe == $past(trg_enable)) else $error("pulse start");
    chk_pulse_width: assert property ($fell(pulse_busy) |-> cnt == `TRG_PULSE_CYC) else $error("width");
    chk_oe_hold: assert property (pulse_busy && $past(pulse_busy) |-> $stable(ttl_trg_oe)) else $error("hold");
    chk_query_value: assert property (query_enabled == trg_enable[$past(query_line)]) else $error("query");
    chk_cmd_apply: assert property (trg_cmd.valid
        |=> trg_enable[$past(trg_cmd.line)] == $past(want)) else $error("cmd");
    chk_reset_clear: assert property (disable iff (1'b0) rst
        |=> trg_enable == 8'h00 && !powerfail_action_value && !open_all_relays) else $error("reset");
    chk_pf_set: assert property (pf_cmd.valid |=> powerfail_action_value == $past(pf_cmd.action))
        else $error("pf set");
    chk_pf_open: assert property (!acfail_n && !powerfail_action_value |-> ##[0:3] open_all_relays)
        else $error("pf open");
    chk_pf_keep: assert property ($rose(open_all_relays) |-> !$past(powerfail_action_value))
        else $error("pf keep");
    cover property (close_dwell_done && !pulse_busy);
    cover property ($rose(open_all_relays));
    cover property (pf_cmd.valid && pf_cmd.action);
endmodule
bind trigger_pulse_powerfail_ctrl trigger_pulse_powerfail_ctrl_monitor mon (.*);

// *** trigger_pulse_powerfail_far.sv ***
`timescale 1ns/100ps
// ****
// Backplane lines and latching relays
// ****
module trigger_pulse_powerfail_far (
    input wire logic clk, open_all_relays, close_all,
    input wire logic [7:0] ttl_trg_out, ttl_trg_oe,
    output logic [7:0] line_level, relays_closed
);
    // Pull-ups hold released lines high
    assign line_level = ~ttl_trg_oe | ttl_trg_out;
    // Latching, so position survives power loss unless opened
    always_ff @(posedge clk) relays_closed <= open_all_relays ? 8'h00 : close_all ? 8'hff : relays_closed;
endmodule

// *** trigger_pulse_powerfail_ctrl_bench.sv ***
`timescale 1ns/100ps
`include "trigger_pulse_powerfail_regs.svh"
module trigger_pulse_powerfail_ctrl_bench;
    logic clk = 0, rst = 1, cdd = 0, ain = 1, cls = 0, qe, act, busy, opn;
    logic [2:0] ql = 3'h0;
    logic [7:0] en, out, oe, lvl, rly;
    logic [12:0] tbl [7] = '{13'h0100, 13'h0e01, 13'h1500, 13'h1602, 13'h1d00, 13'h1a01, 13'h1800};
    trigger_pulse_powerfail_pkg::trg_cmd_t tc = '0;
    trigger_pulse_powerfail_pkg::pf_cmd_t pc = '0;
    int n_errors = 0, compares = 0, cyc = 0, n;
    trigger_pulse_powerfail_ctrl DUT (.clk(clk), .rst(rst), .trg_cmd(tc), .pf_cmd(pc), .query_line(ql),
        .query_enabled(qe), .trg_enable(en), .powerfail_action_value(act), .close_dwell_done(cdd),
        .pulse_busy(busy), .ttl_trg_in(lvl), .ttl_trg_out(out), .ttl_trg_oe(oe), .acfail_n(ain),
        .open_all_relays(opn));
    trigger_pulse_powerfail_far far (.clk(clk), .open_all_relays(opn), .close_all(cls), .ttl_trg_out(out),
        .ttl_trg_oe(oe), .line_level(lvl), .relays_closed(rly));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin
        n_errors++;
        conclude();
    end
    task automatic ck(string nm, logic [7:0] e, s);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic cmd(logic [12:0] c);
        tc = '{1'b1, c[12:10], c[9:8], c[7:0]};
        tick(1);
        tc.valid = 0;
        tick(1);
    endtask
    task automatic t_enable;
        tick(5);
        rst = 0;
        ck("reset", 8'h00, en | {6'h00, qe, act});
        foreach (tbl[i]) cmd(tbl[i]);
        ck("enables", 8'h89, en);
        for (int i = 0; i < 8; i++) begin
            ql = i[2:0];
            tick(1);
            ck("query", 8'h89 >> i & 8'h01, {7'h00, qe});
        end
        $display("t_enable done");
    endtask
    task automatic t_pulse;
        cdd = 1;
        tick(1);
        cdd = 0;
        ck("lines", ~8'h89, lvl);
        cmd(13'h0000);
        n = 3;
        while (busy === 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        ck("width", 8'(`TRG_PULSE_CYC + 1), n[7:0]);
        ck("idle", 8'hff, lvl);
        cdd = 1;
        tick(1);
        cdd = 0;
        ck("lines", ~8'h88, lvl);
        $display("t_pulse done");
    endtask
    task automatic t_pf(logic a, logic [7:0] e);
        rst = 1;
        tick(2);
        rst = 0;
        ck("cleared", 8'h00, en | {7'h00, opn});
        pc = '{1'b1, a};
        cls = 1;
        tick(1);
        pc.valid = 0;
        cls = 0;
        ain = 0;
        tick(6);
        ck("relays", e, rly);
        ck("action", {7'h00, a}, {7'h00, act});
        ain = 1;
        $display("t_pf done");
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        t_enable;
        t_pulse;
        t_pf(`PF_ACTION_OPEN, 8'h00);
        t_pf(`PF_ACTION_SAME, 8'hff);
        conclude;
    end
endmodule
